//--- hw/sleep_pkg.sv
package sleep_pkg;
   // ----------------------------------------
   // device register map (byte offsets on the core link)
   // ----------------------------------------
   localparam logic [7:0] SLEEP_CTRL_OFS = 8'h53;
   localparam logic [7:0] PWR_RED_A_OFS = 8'h64;
   localparam logic [7:0] PWR_RED_B_OFS = 8'h65;
   // sleep_control_register fields
   localparam int SLEEP_EN_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int MODE_MSB = 3;
   localparam logic [3:0] SLEEP_CTRL_RESET = 4'h0;
   // power reduction fields, index into the peripheral vector
   localparam int PERIPH_CNT = 5;
   localparam int PR_TIM0 = 0;
   localparam int PR_TIM1 = 1;
   localparam int PR_SPI = 2;
   localparam int PR_USART = 3;
   localparam int PR_USB = 4;
   localparam int PRA_TIM0_BIT = 5;
   localparam int PRA_TIM1_BIT = 3;
   localparam int PRA_SPI_BIT = 2;
   localparam int PRB_USB_BIT = 7;
   localparam int PRB_USART_BIT = 0;
   localparam logic [4:0] PWR_RED_RESET = 5'h00;
   // sleep mode codes
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
   localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
   localparam logic [2:0] MODE_STANDBY = 3'h6;
   localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int STARTUP_STEP_NS = 1000;
   localparam logic [11:0] STARTUP_STEP_CYCLES = 12'(STARTUP_STEP_NS / CLK_PERIOD_NS);
   localparam logic [11:0] IDLE_WAKE_CYCLES = 12'h001;
   localparam logic [11:0] STANDBY_WAKE_CYCLES = 12'h006;
   localparam logic [11:0] HALT_CYCLES = 12'h004;
   // ----------------------------------------
   // core agent avalon map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] AV_DEV_ADDR = 4'h0;
   localparam logic [3:0] AV_DEV_DATA = 4'h4;
   localparam logic [3:0] AV_CMD = 4'h8;
   localparam logic [3:0] AV_STATUS = 4'hC;
   localparam int CMD_SLEEP_BIT = 0;
   localparam int ST_RUN_BIT = 0;
   localparam int ST_IRQ_BIT = 1;
   localparam int ST_RST_BIT = 2;
endpackage : sleep_pkg

//--- hw/sleep_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// link between the power controller and the core
// ----------------------------------------
interface sleep_link_if;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic sleep_exec;
   logic core_run;
   logic wake_irq;
   logic wake_reset;
   modport device (input reg_addr, reg_wdata, reg_wr, reg_rd, sleep_exec,
                   output reg_rdata, core_run, wake_irq, wake_reset);
   modport core (output reg_addr, reg_wdata, reg_wr, reg_rd, sleep_exec,
                 input reg_rdata, core_run, wake_irq, wake_reset);
endinterface : sleep_link_if

//--- hw/clk_gate_cell.sv
`timescale 1ns/1ps
// ----------------------------------------
// glitch-free clock gate
// ----------------------------------------
module clk_gate_cell (
   input wire logic clk_in, // clock to gate
   input wire logic rst_in, // synchronous reset, high
   input wire logic en_in, // enable, changes after rising edge
   output wire logic gclk_out // gated clock
);
   logic en_low;

   // enable only moves while clk is low, so no pulse is ever cut short
   always_ff @(negedge clk_in) begin
      if (rst_in) begin
         en_low <= 1'b0;
      end else begin
         en_low <= en_in;
      end
   end

   assign gclk_out = clk_in & en_low;
endmodule : clk_gate_cell

//--- hw/sleep_mode_power_controller.sv
`timescale 1ns/1ps
// How it works
// - sleep needs enable flag plus sleep instruction
// - mode 000 idle stops core, flash clocks
// - idle wakes on any external or internal interrupt
// - mode 010 power-down stops oscillator, all clocks
// - power-down wakes only on listed async sources
// - party holds wake level until it is seen
// - power-down wake waits fuse-selected start-up delay
// - mode 011 power-save equals power-down
// - mode 110 standby, crystal only, oscillator on, six-cycle wake
// - mode 111 extended standby, same as standby
// - interrupt wake holds core four extra cycles
// - register file and sram kept across sleep
// - reset while asleep restarts at reset vector
// - reduced peripheral: clock off, registers blocked
// - clearing reduction resumes peripheral unchanged
// - software disables peripheral before gating clock
// - peripheral gating works in active and idle
// - software may disable comparator before idle
// - control register: mode 3:1, enable 0
// - serial interface reduction bit stops its clock
module sleep_mode_power_controller (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // synchronous reset, high
   sleep_link_if.device link, // core side
   input wire logic [3:0] ext_irq_lower_in, // lower external interrupts
   input wire logic [3:0] ext_irq_upper_in, // upper external interrupts, level
   input wire logic pin_change_irqs_in, // any pin change interrupt
   input wire logic twi_match_in, // two-wire address match
   input wire logic wdt_irq_in, // watchdog interrupt
   input wire logic usb_wakeup_irq_in, // usb wake-up interrupt
   input wire logic usb_frame_start_irq_in, // usb start of frame
   input wire logic sync_irq_in, // timer, serial, other synchronous interrupts
   input wire logic sys_reset_req_in, // external, watchdog or brown-out reset
   input wire logic crystal_sel_in, // external crystal or resonator selected
   input wire logic [3:0] clock_source_fuses_in, // start-up time selection
   output logic osc_en_out, // main oscillator enable
   output logic sleeping_out, // device is in a sleep state
   output logic [4:0] periph_io_block_out, // peripheral register access blocked
   output wire logic core_clock_domain_out, // gated core clock
   output wire logic flash_clock_domain_out, // gated flash clock
   output wire logic io_clock_domain_out, // gated io clock
   output wire logic [4:0] periph_clk_out // gated peripheral clocks
);
   typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_DEEP, ST_STANDBY, ST_STARTUP, ST_HALT} pwr_state_e;

   pwr_state_e state;
   logic [3:0] sleep_ctrl;
   logic [4:0] periph_off;
   logic [11:0] count;
   logic by_reset;
   logic [7:0] clk_en;
   logic [7:0] rdata;
   logic core_run;
   logic wake_irq;
   logic wake_reset;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   wire [2:0] mode = sleep_ctrl[sleep_pkg::MODE_MSB:sleep_pkg::MODE_LSB];
   wire wr_ctrl = link.reg_wr && (link.reg_addr == sleep_pkg::SLEEP_CTRL_OFS);
   wire wr_pra = link.reg_wr && (link.reg_addr == sleep_pkg::PWR_RED_A_OFS);
   wire wr_prb = link.reg_wr && (link.reg_addr == sleep_pkg::PWR_RED_B_OFS);
   wire [7:0] ctrl_view = {4'h0, sleep_ctrl}; // upper bits read zero
   wire [7:0] pra_view = 8'(periph_off[sleep_pkg::PR_TIM0]) << sleep_pkg::PRA_TIM0_BIT
                       | 8'(periph_off[sleep_pkg::PR_TIM1]) << sleep_pkg::PRA_TIM1_BIT
                       | 8'(periph_off[sleep_pkg::PR_SPI]) << sleep_pkg::PRA_SPI_BIT;
   wire [7:0] prb_view = 8'(periph_off[sleep_pkg::PR_USB]) << sleep_pkg::PRB_USB_BIT
                       | 8'(periph_off[sleep_pkg::PR_USART]) << sleep_pkg::PRB_USART_BIT;
   wire [7:0] next_rdata = (link.reg_addr == sleep_pkg::SLEEP_CTRL_OFS) ? ctrl_view :
                           (link.reg_addr == sleep_pkg::PWR_RED_A_OFS) ? pra_view :
                           (link.reg_addr == sleep_pkg::PWR_RED_B_OFS) ? prb_view : 8'h00;

   // reduction bits are written as a whole register, only mapped bits stick
   wire [4:0] next_periph_off = {
      wr_prb ? link.reg_wdata[sleep_pkg::PRB_USB_BIT] : periph_off[sleep_pkg::PR_USB],
      wr_prb ? link.reg_wdata[sleep_pkg::PRB_USART_BIT] : periph_off[sleep_pkg::PR_USART],
      wr_pra ? link.reg_wdata[sleep_pkg::PRA_SPI_BIT] : periph_off[sleep_pkg::PR_SPI],
      wr_pra ? link.reg_wdata[sleep_pkg::PRA_TIM1_BIT] : periph_off[sleep_pkg::PR_TIM1],
      wr_pra ? link.reg_wdata[sleep_pkg::PRA_TIM0_BIT] : periph_off[sleep_pkg::PR_TIM0]};

   // register writes and read data, read data lands one edge after reg_rd
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sleep_ctrl <= sleep_pkg::SLEEP_CTRL_RESET;
         periph_off <= sleep_pkg::PWR_RED_RESET;
         rdata <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            sleep_ctrl <= link.reg_wdata[3:0];
         end
         periph_off <= next_periph_off;
         rdata <= link.reg_rd ? next_rdata : rdata;
      end
   end

   // ----------------------------------------
   // sleep entry and wake selection
   // ----------------------------------------
   wire is_idle = (mode == sleep_pkg::MODE_IDLE);
   wire is_deep = (mode == sleep_pkg::MODE_PWR_DOWN) || (mode == sleep_pkg::MODE_PWR_SAVE);
   // standby codes are honoured only with a crystal, the oscillator must be restartable fast
   wire is_stby = ((mode == sleep_pkg::MODE_STANDBY) || (mode == sleep_pkg::MODE_EXT_STANDBY))
                  && crystal_sel_in;
   wire mode_ok = is_idle || is_deep || is_stby; // reserved codes fall out here
   wire go_sleep = link.sleep_exec && sleep_ctrl[sleep_pkg::SLEEP_EN_BIT] && mode_ok;
   wire pwr_state_e sleep_target = is_idle ? ST_IDLE : (is_deep ? ST_DEEP : ST_STANDBY);

   // async-capable sources only; upper pins act as held levels
   wire deep_wake = (|ext_irq_lower_in) || (|ext_irq_upper_in) || pin_change_irqs_in
                    || twi_match_in || wdt_irq_in || usb_wakeup_irq_in;
   wire idle_wake = deep_wake || usb_frame_start_irq_in || sync_irq_in;

   // start-up length depends on which sleep is being left
   wire [11:0] fuse_delay = (12'(clock_source_fuses_in) + 12'h001) * sleep_pkg::STARTUP_STEP_CYCLES;
   wire [11:0] next_delay = (state == ST_IDLE) ? sleep_pkg::IDLE_WAKE_CYCLES :
                            (state == ST_STANDBY) ? sleep_pkg::STANDBY_WAKE_CYCLES :
                            fuse_delay;
   wire asleep = (state == ST_IDLE) || (state == ST_DEEP) || (state == ST_STANDBY);
   wire wake_now = sys_reset_req_in || ((state == ST_IDLE) ? idle_wake : deep_wake);

   // ----------------------------------------
   // power state machine
   // ----------------------------------------
   // core is never reset on an interrupt wake, so its registers and sram simply keep state
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= ST_RUN;
         count <= 12'h000;
         by_reset <= 1'b0;
         core_run <= 1'b1;
         wake_irq <= 1'b0;
         wake_reset <= 1'b0;
      end else begin
         wake_irq <= 1'b0;
         wake_reset <= 1'b0;
         unique case (state)
            ST_RUN: begin
               if (sys_reset_req_in) begin
                  wake_reset <= 1'b1;
               end else if (go_sleep) begin
                  state <= sleep_target;
                  core_run <= 1'b0;
               end
            end
            ST_IDLE, ST_DEEP, ST_STANDBY: begin
               if (wake_now) begin
                  state <= ST_STARTUP;
                  count <= next_delay;
                  by_reset <= sys_reset_req_in;
               end
            end
            ST_STARTUP: begin
               if (count > 12'h001) begin
                  count <= count - 12'h001;
               end else if (by_reset) begin
                  state <= ST_RUN; // restart from the reset vector
                  core_run <= 1'b1;
                  wake_reset <= 1'b1;
               end else begin
                  state <= ST_HALT;
                  count <= sleep_pkg::HALT_CYCLES;
               end
            end
            ST_HALT: begin
               if (count > 12'h001) begin
                  count <= count - 12'h001;
               end else begin
                  state <= ST_RUN; // handler, then the instruction after sleep
                  core_run <= 1'b1;
                  wake_irq <= 1'b1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // clock enables and gates
   // ----------------------------------------
   wire core_on = (state == ST_RUN) || (state == ST_HALT); // off in every sleep
   wire io_on = core_on || (state == ST_IDLE); // io keeps running in idle
   wire osc_on = (state != ST_DEEP);
   // peripheral clocks follow io, so reduction works in active and idle alike
   wire [4:0] periph_on = {5{io_on}} & ~periph_off;
   wire [7:0] next_clk_en = {periph_on, io_on, core_on, core_on};

   // enables come from flops so the gate cells see clean levels
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         clk_en <= 8'hFF;
         osc_en_out <= 1'b1;
         sleeping_out <= 1'b0;
         periph_io_block_out <= sleep_pkg::PWR_RED_RESET;
      end else begin
         clk_en <= next_clk_en;
         osc_en_out <= osc_on;
         sleeping_out <= asleep;
         periph_io_block_out <= periph_off;
      end
   end

   // gating only stops edges, no peripheral is reset, so it resumes where it stopped
   wire [7:0] gclk;
   generate
      for (genvar i = 0; i < 8; i++) begin : g_gate
         clk_gate_cell u_gate (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .en_in(clk_en[i]),
            .gclk_out(gclk[i])
         );
      end
   endgenerate

   assign core_clock_domain_out = gclk[0];
   assign flash_clock_domain_out = gclk[1];
   assign io_clock_domain_out = gclk[2];
   assign periph_clk_out = gclk[7:3];

   // link answers
   assign link.reg_rdata = rdata;
   assign link.core_run = core_run;
   assign link.wake_irq = wake_irq;
   assign link.wake_reset = wake_reset;
endmodule : sleep_mode_power_controller

//--- hw/sleep_core_agent.sv
`timescale 1ns/1ps
// ----------------------------------------
// core end: turns avalon orders into register writes and sleep instructions
// ----------------------------------------
module sleep_core_agent (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // synchronous reset, high
   sleep_link_if.core link, // controller side
   input wire logic [3:0] avs_address_in, // byte address
   input wire logic avs_read_in, // read request
   input wire logic avs_write_in, // write request
   input wire logic [31:0] avs_writedata_in, // write data
   output logic [31:0] avs_readdata_out, // read data
   output logic avs_waitrequest_out // stall, low for one cycle per answer
);
   logic [7:0] dev_addr;
   logic [1:0] stage;
   logic woke_irq;
   logic woke_reset;
   logic reg_wr;
   logic reg_rd;
   logic sleep_exec;
   logic [7:0] wdata;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire req = (avs_read_in || avs_write_in) && avs_waitrequest_out;
   wire at_addr = (avs_address_in == sleep_pkg::AV_DEV_ADDR);
   wire at_data = (avs_address_in == sleep_pkg::AV_DEV_DATA);
   wire at_cmd = (avs_address_in == sleep_pkg::AV_CMD);
   wire at_stat = (avs_address_in == sleep_pkg::AV_STATUS);
   // a sleeping core executes nothing, so device writes and commands wait for it
   wire stall = avs_write_in && (at_data || at_cmd) && !link.core_run;
   wire clr = req && avs_write_in && at_stat && (stage == 2'd0);
   wire [31:0] stat_view = {29'h0, woke_reset, woke_irq, link.core_run};
   wire [31:0] next_rdata = at_addr ? {24'h0, dev_addr} : (at_stat ? stat_view : 32'h0);

   // sticky wake causes, a new wake wins over a clear in the same cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         woke_irq <= 1'b0;
         woke_reset <= 1'b0;
      end else begin
         woke_irq <= link.wake_irq || (woke_irq && !(clr && avs_writedata_in[sleep_pkg::ST_IRQ_BIT]));
         woke_reset <= link.wake_reset || (woke_reset && !(clr && avs_writedata_in[sleep_pkg::ST_RST_BIT]));
      end
   end

   // ----------------------------------------
   // slave sequencer
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0;
         dev_addr <= 8'h00;
         stage <= 2'd0;
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         sleep_exec <= 1'b0;
         wdata <= 8'h00;
      end else begin
         avs_waitrequest_out <= 1'b1;
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         sleep_exec <= 1'b0;
         if (!avs_waitrequest_out) begin
            stage <= 2'd0;
         end else if (req && stage == 2'd0 && !stall) begin
            if (avs_read_in && at_data) begin
               reg_rd <= 1'b1;
               stage <= 2'd1;
            end else begin
               avs_waitrequest_out <= 1'b0;
               avs_readdata_out <= next_rdata;
               if (avs_write_in && at_addr) begin
                  dev_addr <= avs_writedata_in[7:0];
               end
               reg_wr <= avs_write_in && at_data;
               wdata <= avs_writedata_in[7:0];
               sleep_exec <= avs_write_in && at_cmd && avs_writedata_in[sleep_pkg::CMD_SLEEP_BIT];
            end
         end else if (stage == 2'd1) begin
            stage <= 2'd2;
         end else if (stage == 2'd2) begin
            avs_readdata_out <= {24'h0, link.reg_rdata};
            avs_waitrequest_out <= 1'b0;
         end
      end
   end

   assign link.reg_addr = dev_addr;
   assign link.reg_wdata = wdata;
   assign link.reg_wr = reg_wr;
   assign link.reg_rd = reg_rd;
   assign link.sleep_exec = sleep_exec;
endmodule : sleep_core_agent

//--- verification/sleep_checker.sv
`timescale 1ns/1ps
module sleep_checker (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // sync reset, high
   input wire logic [7:0] reg_addr, // device offset
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [7:0] reg_rdata, // read data
   input wire logic sleep_exec, // sleep instruction
   input wire logic core_run, // core may run
   input wire logic wake_irq, // interrupt wake pulse
   input wire logic wake_reset // reset wake pulse
);
   // ----------------------------------------
   // shadow of the sleep control register
   // ----------------------------------------
   logic [3:0] ctl;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctl <= 4'h0;
      end else if (reg_wr && reg_addr == sleep_pkg::SLEEP_CTRL_OFS) begin
         ctl <= reg_wdata[3:0];
      end
   end
   // standby codes hang on the crystal pin, which the link cannot see, so they are left out
   wire go = sleep_exec && core_run && ctl[0];
   wire ok_mode = ctl[3:1] == 3'h0 || ctl[3:1] == 3'h2 || ctl[3:1] == 3'h3;
   wire bad_mode = ctl[3:1] == 3'h1 || ctl[3:2] == 2'b10;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_enter; go && ok_mode |=> !core_run; endproperty
   a_enter: assert property (p_enter) else $error("valid sleep not entered");
   property p_no_se; sleep_exec && core_run && !ctl[0] |=> core_run [*2]; endproperty
   a_no_se: assert property (p_no_se) else $error("slept without enable");
   property p_reserved; go && bad_mode |=> core_run [*2]; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code slept");
   property p_fall; $fell(core_run) |-> $past(sleep_exec); endproperty
   a_fall: assert property (p_fall) else $error("core stopped without sleep");
   property p_halt; wake_irq |-> core_run && !$past(core_run) && !$past(core_run, 5); endproperty
   a_halt: assert property (p_halt) else $error("interrupt wake too short");
   property p_rst_wake; wake_reset |-> core_run; endproperty
   a_rst_wake: assert property (p_rst_wake) else $error("reset wake left core held");
   property p_ctl_read; $past(reg_rd) && $past(reg_addr) == sleep_pkg::SLEEP_CTRL_OFS |-> reg_rdata == {4'h0, $past(ctl)};
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");
   property p_pra_read; $past(reg_rd) && $past(reg_addr) == sleep_pkg::PWR_RED_A_OFS |-> (reg_rdata & 8'hD3) == 8'h00;
   endproperty
   a_pra_read: assert property (p_pra_read) else $error("reduction reserved bit set");
   property p_rd_hold; !$past(reg_rd) |-> $stable(reg_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : sleep_checker

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk_in, rst_in, avs_read, avs_write, avs_wait, osc_en, sleeping, cclk, fclk, ioclk;
   logic [3:0] avs_address, irq_lo, irq_hi, fuses;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic pin_chg, twi, wdt, usb_wk, usb_sof, sync_irq, sys_rst, xtal;
   logic [4:0] io_block, pclk, blk;
   logic [7:0] r, a, b;
   int n_errors, checked, cyc, seed, n, d, src;
   int cnt[8];
   int base[8];
   sleep_link_if link_i ();
   sleep_mode_power_controller sleep_mode_power_controller_i (.clk_in(clk_in), .rst_in(rst_in), .link(link_i),
      .ext_irq_lower_in(irq_lo), .ext_irq_upper_in(irq_hi), .pin_change_irqs_in(pin_chg), .twi_match_in(twi),
      .wdt_irq_in(wdt), .usb_wakeup_irq_in(usb_wk), .usb_frame_start_irq_in(usb_sof), .sync_irq_in(sync_irq),
      .sys_reset_req_in(sys_rst), .crystal_sel_in(xtal), .clock_source_fuses_in(fuses), .osc_en_out(osc_en),
      .sleeping_out(sleeping), .periph_io_block_out(io_block), .core_clock_domain_out(cclk),
      .flash_clock_domain_out(fclk), .io_clock_domain_out(ioclk), .periph_clk_out(pclk));
   sleep_core_agent sleep_core_agent_i (.clk_in(clk_in), .rst_in(rst_in), .link(link_i),
      .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_wait));
   sleep_checker sleep_checker_i (.clk_in(clk_in), .rst_in(rst_in), .reg_addr(link_i.reg_addr),
      .reg_wdata(link_i.reg_wdata), .reg_wr(link_i.reg_wr), .reg_rd(link_i.reg_rd), .reg_rdata(link_i.reg_rdata),
      .sleep_exec(link_i.sleep_exec), .core_run(link_i.core_run), .wake_irq(link_i.wake_irq),
      .wake_reset(link_i.wake_reset));
   // ----------------------------------------
   // clock, edge counters of the gated clocks, watchdog
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge cclk) cnt[5]++;
   always @(posedge ioclk) cnt[6]++;
   always @(posedge fclk) cnt[7]++;
   for (genvar g = 0; g < 5; g++) begin : gcnt
      always @(posedge pclk[g]) cnt[g]++;
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 50000) begin
         n_errors++;
         conclude();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task conclude();
      $display("errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   // one avalon transfer, held until waitrequest is sampled low at a rising edge
   task av(input logic wr, input logic [3:0] ad, input logic [31:0] dt);
      @(posedge clk_in);
      avs_address <= ad;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= dt;
      do @(posedge clk_in); while (avs_wait !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task dev_wr(input logic [7:0] ofs, input logic [7:0] v);
      av(1'b1, sleep_pkg::AV_DEV_ADDR, {24'h0, ofs});
      av(1'b1, sleep_pkg::AV_DEV_DATA, {24'h0, v});
   endtask : dev_wr
   task dev_rd(input logic [7:0] ofs);
      av(1'b1, sleep_pkg::AV_DEV_ADDR, {24'h0, ofs});
      av(1'b0, sleep_pkg::AV_DEV_DATA, 32'h0);
      r = q[7:0];
   endtask : dev_rd
   // level sources are held until the core runs again
   task drive(input int k, input logic v);
      case (k)
         0: irq_lo <= {4{v}};
         1: irq_hi <= {4{v}};
         2: pin_chg <= v;
         3: twi <= v;
         4: usb_wk <= v;
         5: irq_lo[2] <= v;
         6: sync_irq <= v;
         7: wdt <= v;
         default: usb_sof <= v;
      endcase
   endtask : drive
   task clocks_after(input int c);
      repeat (2) @(posedge clk_in); // gates close two edges after the request returns
      base = cnt;
      repeat (c) @(posedge clk_in);
   endtask : clocks_after
   function automatic logic enters(input logic [2:0] m, input logic x);
      return m == 3'h0 || m == 3'h2 || m == 3'h3 || (x && m[2:1] == 2'b11);
   endfunction : enters
   function automatic int delay(input logic [2:0] m, input logic [3:0] f);
      return (m == 3'h0) ? 5 : (m[2] ? 10 : (int'(f) + 1) * 100 + 4);
   endfunction : delay
   task wait_run();
      n = 0;
      while (link_i.core_run !== 1'b1 && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
   endtask : wait_run
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rst_in, avs_read, avs_write, avs_address, avs_writedata, irq_lo, irq_hi, fuses} = {1'b1, 50'h0};
      {pin_chg, twi, wdt, usb_wk, usb_sof, sync_irq, sys_rst, xtal} = 8'h01;
      seed = 3586;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      dev_rd(sleep_pkg::SLEEP_CTRL_OFS);
      check("control reset", r, 8'h00);
      dev_rd(8'h70);
      check("unmapped device read", r, 8'h00);
      av(1'b0, 4'h2, 32'h0);
      check("unmapped avalon read", q, 32'h0);
      for (int i = 0; i < 5; i++) begin
         a = (i == 4) ? 8'hFF : 8'($random(seed));
         b = 8'($random(seed));
         dev_wr(sleep_pkg::SLEEP_CTRL_OFS, a);
         dev_rd(sleep_pkg::SLEEP_CTRL_OFS);
         check("control readback", r, {4'h0, a[3:0]});
         dev_wr(sleep_pkg::PWR_RED_A_OFS, a);
         dev_wr(sleep_pkg::PWR_RED_B_OFS, b);
         dev_rd(sleep_pkg::PWR_RED_A_OFS);
         check("reduction a", r, a & 8'h2C);
         dev_rd(sleep_pkg::PWR_RED_B_OFS);
         check("reduction b", r, b & 8'h81);
         blk = {b[7], b[0], a[2], a[3], a[5]};
         check("register block", io_block, blk);
         clocks_after(8);
         for (int g = 0; g < 5; g++) check("peripheral clock", cnt[g] != base[g], !blk[g]);
      end
      // every code with crystal, then both standby codes without it
      for (int k = 0; k < 10; k++) begin
         dev_wr(sleep_pkg::SLEEP_CTRL_OFS, 8'h00);
         av(1'b1, sleep_pkg::AV_CMD, 32'h1); // no enable flag, core keeps running
         xtal <= (k < 8);
         fuses <= 4'($unsigned($random(seed)) % 3);
         dev_wr(sleep_pkg::SLEEP_CTRL_OFS, {4'h0, 3'(k < 8 ? k : k - 2), 1'b1});
         av(1'b1, sleep_pkg::AV_CMD, 32'h1);
         clocks_after(8);
         check("sleep entered", sleeping, enters(3'(k < 8 ? k : k - 2), k < 8));
         if (sleeping === 1'b1) begin
            check("oscillator", osc_en, k == 0 || (k >= 6 && k < 8));
            check("core and flash clock", {cnt[5] != base[5], cnt[7] != base[7]}, 2'b00);
            check("io clock", cnt[6] != base[6], k == 0);
            if (k == 0) begin
               for (int g = 0; g < 5; g++) check("idle gating", cnt[g] != base[g], !blk[g]);
            end else begin
               sync_irq <= 1'b1;
               usb_sof <= 1'b1;
               repeat (30) @(posedge clk_in);
               check("ignored source", sleeping, 1'b1);
               sync_irq <= 1'b0;
               usb_sof <= 1'b0;
            end
            src = (k == 0) ? 6 + $unsigned($random(seed)) % 3 : $unsigned($random(seed)) % 6;
            d = delay(3'(k), fuses);
            drive(src, 1'b1);
            wait_run();
            drive(src, 1'b0);
            check("wake delay", n >= d + 1 && n <= d + 4, 1'b1);
            av(1'b0, sleep_pkg::AV_STATUS, 32'h0);
            check("interrupt wake flag", q[2:0], 3'h3);
            av(1'b1, sleep_pkg::AV_STATUS, 32'h6);
         end
      end
      // reset while in power-down restarts rather than resumes
      dev_wr(sleep_pkg::SLEEP_CTRL_OFS, {4'h0, sleep_pkg::MODE_PWR_DOWN, 1'b1});
      av(1'b1, sleep_pkg::AV_CMD, 32'h1);
      repeat (4) @(posedge clk_in);
      sys_rst <= 1'b1;
      wait_run();
      sys_rst <= 1'b0;
      av(1'b0, sleep_pkg::AV_STATUS, 32'h0);
      check("reset wake flag", q[2:0], 3'h5);
      dev_wr(sleep_pkg::PWR_RED_A_OFS, 8'h00);
      dev_wr(sleep_pkg::PWR_RED_B_OFS, 8'h00);
      clocks_after(8);
      for (int g = 0; g < 5; g++) check("clock resumed", cnt[g] != base[g], 1'b1);
      conclude();
   end
endmodule : tb
